// file: ptt_top.sv
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "ptt_defines.svh"
module ptt_top #(
   parameter int GRACE_CYC = `PTT_GRACE_CYC,
   parameter bit MOBILE = 1'b0,
   parameter bit FIXED_REV = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic thermal_alarm_n_i,
   input wire logic io_valid_i,
   input wire logic [15:0] io_addr_i,
   output logic cpu_stop_clock_n_o,
   output logic system_mgmt_interrupt_n_o,
   output logic sci_o,
   output logic io_forward_o,
   output logic [2:0] d9_reload_o
);
   localparam int HIGH_CYC = MOBILE ? `PTT_HIGH_MOB_CYC : `PTT_HIGH_CYC;
   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [3:0] ctrl_ff, nxt_ctrl;        // 0 therm en, 1 sci sel, 2 smi pend, 3 sci pend
   logic [5:0] duty_ff, nxt_duty;        // [2:0] thermal duty, [5:3] throttle duty
   logic [13:0] trap_en_ff, nxt_trap_en;
   logic [13:0] dec_en_ff, nxt_dec_en;
   logic [4:0] d9_ff, nxt_d9;            // idle, burst, global, monitor, trap
   logic [15:0] d9_base_ff, nxt_d9_base, d9_mask_ff, nxt_d9_mask;
   logic [13:0] trap_stat_ff, nxt_trap_stat;
   logic [31:0] rdata_ff, nxt_rdata;
   logic alarm_q_ff;
   logic alarm_edge;
   logic [2:0] duty_in;
   logic [2:0] thr_in;
   logic [13:0] trap_hit;
   ptt_io_if io ();
   assign io.io_valid = io_valid_i;
   assign io.io_addr = io_addr_i;
   logic [16*`PTT_NDEV-1:0] base_v, mask_v;
   always_comb begin
      base_v = '0;
      mask_v = {16*`PTT_NDEV{1'b1}};
      base_v[16*9 +: 16] = d9_base_ff;
      mask_v[16*9 +: 16] = d9_mask_ff;
   end
   ptt_io_decode #(.NDEV(`PTT_NDEV)) u_dec (.bus(io.dec), .base_i(base_v), .mask_i(mask_v));
   assign alarm_edge = alarm_q_ff && !thermal_alarm_n_i;
   // Base revision refuses the reserved 87% encoding and keeps the old value.
   assign duty_in = reg_wdata_i[2:0];
   assign thr_in = reg_wdata_i[5:3];
   always_comb begin
      trap_hit = trap_en_ff & io.dev_hit;
      // Device 9 trap ignores monitor enable, base and mask on legacy ports.
      trap_hit[9] = trap_hit[9] || (d9_ff[4] && io.d9_legacy); // see [R11]
   end
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_duty = duty_ff;
      nxt_trap_en = trap_en_ff;
      nxt_dec_en = dec_en_ff;
      nxt_d9 = d9_ff;
      nxt_d9_base = d9_base_ff;
      nxt_d9_mask = d9_mask_ff;
      nxt_trap_stat = trap_stat_ff;
      nxt_rdata = 32'h00000000;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `PTT_A_CTRL: nxt_ctrl = {ctrl_ff[3:2] & ~reg_wdata_i[3:2], reg_wdata_i[1:0]};
            `PTT_A_DUTY: begin
               if (FIXED_REV || duty_in != `PTT_DUTY_RSVD) nxt_duty[2:0] = duty_in; // see [R5]
               if (FIXED_REV || thr_in != `PTT_DUTY_RSVD) nxt_duty[5:3] = thr_in; // see [R5]
            end
            `PTT_A_TRAP: nxt_trap_en = reg_wdata_i[13:0];
            `PTT_A_DECODE: nxt_dec_en = reg_wdata_i[13:0];
            `PTT_A_D9: nxt_d9 = reg_wdata_i[4:0];
            `PTT_A_D9BASE: nxt_d9_base = reg_wdata_i[15:0];
            `PTT_A_D9MASK: nxt_d9_mask = reg_wdata_i[15:0];
            `PTT_A_STAT: nxt_trap_stat = trap_stat_ff & ~reg_wdata_i[13:0];
            default: ;
         endcase
      end
      // Hardware sets win over software clears.
      if (alarm_edge && ctrl_ff[0] && !ctrl_ff[1]) nxt_ctrl[2] = 1'b1; // see [R1]
      if (alarm_edge && ctrl_ff[0] && ctrl_ff[1]) nxt_ctrl[3] = 1'b1; // see [R2]
      nxt_trap_stat = nxt_trap_stat | trap_hit;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `PTT_A_CTRL: nxt_rdata = {28'h0000000, ctrl_ff};
            `PTT_A_DUTY: nxt_rdata = {26'h0000000, duty_ff};
            `PTT_A_TRAP: nxt_rdata = {18'h00000, trap_en_ff};
            `PTT_A_DECODE: nxt_rdata = {18'h00000, dec_en_ff};
            `PTT_A_D9: nxt_rdata = {27'h0000000, d9_ff};
            `PTT_A_D9BASE: nxt_rdata = {16'h0000, d9_base_ff};
            `PTT_A_D9MASK: nxt_rdata = {16'h0000, d9_mask_ff};
            `PTT_A_STAT: nxt_rdata = {18'h00000, trap_stat_ff};
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= 4'h0;
         duty_ff <= 6'h00;
         trap_en_ff <= 14'h0000;
         dec_en_ff <= 14'h0000;
         d9_ff <= 5'h00;
         d9_base_ff <= 16'h0000;
         d9_mask_ff <= 16'h0000;
         trap_stat_ff <= 14'h0000;
         rdata_ff <= 32'h00000000;
         alarm_q_ff <= 1'b1;
      end else begin
         ctrl_ff <= nxt_ctrl;
         duty_ff <= nxt_duty;
         trap_en_ff <= nxt_trap_en;
         dec_en_ff <= nxt_dec_en;
         d9_ff <= nxt_d9;
         d9_base_ff <= nxt_d9_base;
         d9_mask_ff <= nxt_d9_mask;
         trap_stat_ff <= nxt_trap_stat;
         rdata_ff <= nxt_rdata;
         alarm_q_ff <= thermal_alarm_n_i;
      end
   end
   assign reg_rdata_o = rdata_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pins, forwarding and device 9 reloads.
   logic smi_n_ff, sci_ff, fwd_ff;
   logic [2:0] rld_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         smi_n_ff <= 1'b1;
         sci_ff <= 1'b0;
         fwd_ff <= 1'b0;
         rld_ff <= 3'h0;
      end else begin
         smi_n_ff <= !(nxt_ctrl[2] || (nxt_trap_stat != 14'h0000)); // see [R1]
         sci_ff <= nxt_ctrl[3]; // see [R2]
         // Trapped cycles are still passed on, so a powered-down device sees them.
         fwd_ff <= io_valid_i && ((|(io.dev_hit & dec_en_ff)) || (|trap_hit)); // see [R7]
         rld_ff <= io.d9_legacy ? d9_ff[2:0] : 3'h0; // see [R10]
      end
   end
   assign system_mgmt_interrupt_n_o = smi_n_ff;
   assign sci_o = sci_ff;
   assign io_forward_o = fwd_ff;
   assign d9_reload_o = rld_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Grace timer and stop-clock throttling.
   ptt_pkg::ptt_state_t st_ff, nxt_st;
   logic [31:0] cnt_ff, nxt_cnt;
   logic [15:0] ph_ff, nxt_ph;
   logic [15:0] hi_ff, nxt_hi;
   logic stp_n_ff, nxt_stp_n;
   logic [15:0] low_len;
   // Duty code n asserts stop clock for n eighths of the period.
   assign low_len = {5'h00, duty_ff[2:0], 8'h00} >> 3;
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_ph = ph_ff;
      nxt_hi = (hi_ff != 16'h0000) ? hi_ff - 16'h0001 : hi_ff;
      nxt_stp_n = stp_n_ff;
      case (st_ff)
         ptt_pkg::st_idle: begin
            nxt_stp_n = 1'b1;
            if (alarm_edge && ctrl_ff[0]) begin
               nxt_st = ptt_pkg::st_grace;
               nxt_cnt = 32'h00000000;
            end
         end
         ptt_pkg::st_grace: begin
            nxt_cnt = cnt_ff + 32'h00000001;
            if (thermal_alarm_n_i) nxt_st = ptt_pkg::st_idle;
            else if (cnt_ff >= 32'(GRACE_CYC - 1)) nxt_st = ptt_pkg::st_throttle; // see [R3]
         end
         ptt_pkg::st_throttle: begin
            nxt_ph = (ph_ff == `PTT_PERIOD_CYC - 16'h0001) ? 16'h0000 : ph_ff + 16'h0001;
            if (!stp_n_ff) begin
               if (ph_ff >= low_len) begin
                  nxt_stp_n = 1'b1;
                  if (FIXED_REV) nxt_hi = 16'(HIGH_CYC - 1); // see [R6]
               end
            end else if (hi_ff == 16'h0000 && ph_ff < low_len) begin
               nxt_stp_n = 1'b0; // see [R6]
            end
            // Leaving throttling lets stop clock go high at once, so idle never shows it low.
            if (thermal_alarm_n_i) begin
               nxt_st = ptt_pkg::st_idle;
               nxt_ph = 16'h0000;
               nxt_stp_n = 1'b1;
               if (FIXED_REV && !stp_n_ff) nxt_hi = 16'(HIGH_CYC - 1); // see [R6]
            end
         end
         default: nxt_st = ptt_pkg::st_idle;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= ptt_pkg::st_idle;
         cnt_ff <= 32'h00000000;
         ph_ff <= 16'h0000;
         hi_ff <= 16'h0000;
         stp_n_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         ph_ff <= nxt_ph;
         hi_ff <= nxt_hi;
         stp_n_ff <= nxt_stp_n;
      end
   end
   assign cpu_stop_clock_n_o = stp_n_ff;
   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_alarm_smi;
      alarm_edge && ctrl_ff[0] && !ctrl_ff[1];
   endsequence
   chk_alarm_raises_smi: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R1]
      s_alarm_smi |=> ##1 !system_mgmt_interrupt_n_o) else $error("No SMI after alarm.");
   chk_alarm_raises_sci: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R2]
      alarm_edge && ctrl_ff[0] && ctrl_ff[1] |=> ##1 sci_o) else $error("No SCI after alarm.");
   chk_grace_no_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R3]
      st_ff != ptt_pkg::st_throttle |-> cpu_stop_clock_n_o) else $error("Stop before grace.");
   chk_stop_high_min: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R6]
      FIXED_REV && $rose(cpu_stop_clock_n_o) && st_ff == ptt_pkg::st_throttle
      |-> hi_ff == 16'(HIGH_CYC - 1)) else $error("Stop high time short.");
   chk_high_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R6]
      hi_ff != 16'h0000 |-> ##1 cpu_stop_clock_n_o) else $error("Stop fell early.");
   chk_duty_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R5]
      !FIXED_REV |-> duty_ff[2:0] != `PTT_DUTY_RSVD) else $error("Reserved duty held.");
   chk_trap_forward: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R7]
      io_valid_i && (|trap_hit) |=> io_forward_o) else $error("Trapped cycle dropped.");
   chk_d9_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R10]
      io.d9_legacy && d9_ff[0] |=> d9_reload_o[0]) else $error("No device 9 reload.");
   chk_d9_trap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see [R11]
      io.d9_legacy && d9_ff[4] |=> trap_stat_ff[9] ##1 !system_mgmt_interrupt_n_o)
      else $error("No device 9 trap.");
endmodule

// file: ptt_defines.svh
`ifndef PTT_DEFINES_SVH
`define PTT_DEFINES_SVH
// Contract
// [R1] Thermal alarm with enable set and SCI routing clear raises the management interrupt.
// [R2] Thermal alarm with enable and SCI routing both set raises SCI instead.
// [R3] Throttling starts only after a two second grace period following the report.
// [R4] Handler software disables clock control within the grace period on base revision.
// [R5] Base revision treats the 87% duty encodings as reserved; software avoids them.
// [R6] Fixed revisions hold stop clock high at least 32 us, 26.7 us mobile.
// [R7] Enabled device traps still forward the trapped cycle to expansion and IDE buses.
// [R8] Handler saves IDE timing and selects safe PIO on IDE power down.
// [R9] Handler disables expansion decode and enables trap on non-IDE power down.
// [R10] Device 9 timer enables reload on 62h/66h accesses regardless of monitor enable.
// [R11] Device 9 trap enable traps 62h/66h regardless of monitor, base and mask.
`define PTT_CLK_MHZ 125
`define PTT_GRACE_MS 2000
`define PTT_GRACE_CYC (`PTT_GRACE_MS * 1000 * `PTT_CLK_MHZ)
`define PTT_HIGH_NS 32000
`define PTT_HIGH_MOB_NS 26700
`define PTT_HIGH_CYC ((`PTT_HIGH_NS * `PTT_CLK_MHZ + 999) / 1000)
`define PTT_HIGH_MOB_CYC ((`PTT_HIGH_MOB_NS * `PTT_CLK_MHZ + 999) / 1000)
`define PTT_DUTY_RSVD 3'h7
`define PTT_DUTY_FULL 3'h0
`define PTT_LEGACY_A 16'h0062
`define PTT_LEGACY_B 16'h0066
`define PTT_DEV9 4'h9
`define PTT_NDEV 14
`define PTT_PERIOD_CYC 16'h0100
`define PTT_A_CTRL 4'h0
`define PTT_A_DUTY 4'h1
`define PTT_A_TRAP 4'h2
`define PTT_A_DECODE 4'h3
`define PTT_A_D9 4'h4
`define PTT_A_D9BASE 4'h5
`define PTT_A_D9MASK 4'h6
`define PTT_A_STAT 4'h7
`endif

// file: ptt_pkg.sv
package ptt_pkg;
   typedef enum logic [1:0] {st_idle, st_grace, st_throttle} ptt_state_t;
endpackage

// file: ptt_io_if.sv
`timescale 1ns/10ps
interface ptt_io_if;
   logic io_valid;
   logic [15:0] io_addr;
   logic [13:0] dev_hit;
   logic d9_legacy;
   modport dec (input io_valid, input io_addr, output dev_hit, output d9_legacy);
   modport use_side (output io_valid, output io_addr, input dev_hit, input d9_legacy);
endinterface

// file: ptt_io_decode.sv
`timescale 1ns/10ps
`include "ptt_defines.svh"
module ptt_io_decode #(
   parameter int NDEV = `PTT_NDEV
) (
   ptt_io_if.dec bus,
   input wire logic [16*NDEV-1:0] base_i,
   input wire logic [16*NDEV-1:0] mask_i
);
   // Address match with per-device don't-care mask.
   function automatic logic hit(input logic [15:0] a, input logic [15:0] b,
         input logic [15:0] m);
      hit = ((a ^ b) & ~m) == 16'h0000;
   endfunction
   genvar g;
   generate
      for (g = 0; g < NDEV; g++) begin : g_dev
         assign bus.dev_hit[g] = bus.io_valid &&
            hit(bus.io_addr, base_i[16*g +: 16], mask_i[16*g +: 16]);
      end
   endgenerate
   // Legacy 62h/66h decode is hard-wired and bypasses base and mask.
   assign bus.d9_legacy = bus.io_valid &&
      (hit(bus.io_addr, `PTT_LEGACY_A, 16'h0000) || hit(bus.io_addr, `PTT_LEGACY_B, 16'h0000));
endmodule

// file: ptt_host_model.sv
`timescale 1ns/10ps
// Stands in for the processor. It only watches stop-clock and records the shortest
// high stretch between two low stretches, since a short one is what it would miss.
module ptt_host_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cpu_stop_clock_n_i,
   output int min_high_o,
   output int low_count_o
);
   int run;
   logic seen_low;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run <= 0;
         seen_low <= 1'h0;
         min_high_o <= 32'h7FFFFFFF;
         low_count_o <= 0;
      end else if (cpu_stop_clock_n_i) begin
         run <= run + 1;
      end else begin
         if (seen_low && run > 0 && run < min_high_o) begin
            min_high_o <= run;
         end
         seen_low <= 1'h1;
         run <= 0;
         low_count_o <= low_count_o + 1;
      end
   end
endmodule

// file: tb_pm_thermal_throttle_and_device_trap.sv
`timescale 1ns/10ps
module tb_pm_thermal_throttle_and_device_trap;
   logic clk_i = 1'h0;
   logic rst_n_i = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_s = 1'h0;
   logic rd_s = 1'h0;
   logic [31:0] rdata;
   logic alarm_n = 1'h1;
   logic io_valid = 1'h0;
   logic [15:0] io_addr = 16'h0;
   logic stop_n, smi_n, sci, fwd;
   logic [2:0] rl;
   int min_high, low_count, fails = 0, comparisons = 0, cyc = 0;
   always #4 clk_i = ~clk_i;
   // A small grace count keeps the run short; the throttle logic is the same.
   ptt_top #(.GRACE_CYC(50)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .thermal_alarm_n_i(alarm_n), .io_valid_i(io_valid), .io_addr_i(io_addr),
      .cpu_stop_clock_n_o(stop_n), .system_mgmt_interrupt_n_o(smi_n), .sci_o(sci),
      .io_forward_o(fwd), .d9_reload_o(rl));
   ptt_host_model host (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_stop_clock_n_i(stop_n),
      .min_high_o(min_high), .low_count_o(low_count));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i) begin wr_s <= 1'h1; addr <= a; wdata <= d; end
      @(posedge clk_i) wr_s <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i) begin rd_s <= 1'h1; addr <= a; end
      @(posedge clk_i) rd_s <= 1'h0;
      #1 d = rdata;
   endtask
   // Pulses may land one or two edges after the cycle, so both are gathered.
   task automatic io(input logic [15:0] a, output logic f, output logic [2:0] r);
      @(posedge clk_i) begin io_valid <= 1'h1; io_addr <= a; end
      f = 1'h0;
      r = 3'h0;
      repeat (2) begin @(posedge clk_i) io_valid <= 1'h0; #1 f |= fwd; r |= rl; end
   endtask
   task automatic complete_run;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic scn_thermal_smi;
      int i;
      wr(4'h0, 32'h1);
      wr(4'h1, 32'h4);
      @(posedge clk_i) alarm_n <= 1'h0;
      repeat (3) @(posedge clk_i);
      #1 chk("smi_n", smi_n, 32'h0);
      chk("sci", sci, 32'h0);
      repeat (40) @(posedge clk_i);
      #1 chk("stop_n in grace", stop_n, 32'h1);
      for (i = 0; i < 400 && stop_n !== 1'h0; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk("stop_n throttle", stop_n, 32'h0);
      repeat (12000) @(posedge clk_i);
      chk("min high", min_high >= 4000 && min_high < 100000, 32'h1);
      alarm_n <= 1'h1;
      wr(4'h0, 32'h5);
      repeat (10) @(posedge clk_i);
      #1 chk("smi_n clear", smi_n, 32'h1);
      chk("stop_n idle", stop_n, 32'h1);
   endtask
   task automatic scn_thermal_sci;
      logic [31:0] d;
      wr(4'h0, 32'h3);
      @(posedge clk_i) alarm_n <= 1'h0;
      repeat (3) @(posedge clk_i);
      #1 chk("sci", sci, 32'h1);
      chk("smi_n", smi_n, 32'h1);
      rd(4'h0, d);
      chk("ctrl", d, 32'hB);
      // The handler turns clock control off inside the grace period.
      wr(4'h1, 32'h0);
      rd(4'h1, d);
      chk("duty off", d, 32'h0);
      repeat (60) @(posedge clk_i);
      #1 chk("stop_n no control", stop_n, 32'h1);
      alarm_n <= 1'h1;
      wr(4'h0, 32'h8);
      repeat (3) @(posedge clk_i);
      #1 chk("sci clear", sci, 32'h0);
   endtask
   task automatic scn_dev9;
      logic f;
      logic [2:0] r;
      logic [31:0] d;
      int i;
      wr(4'h2, 32'h200);
      wr(4'h4, 32'h10);
      wr(4'h5, 32'h1234);
      wr(4'h6, 32'h0);
      io(16'h0064, f, r);
      rd(4'h7, d);
      chk("no trap", d, 32'h0);
      io(16'h0062, f, r);
      chk("fwd", f, 32'h1);
      #1 chk("trap smi_n", smi_n, 32'h0);
      rd(4'h7, d);
      chk("trap status", d, 32'h200);
      wr(4'h7, 32'h200);
      repeat (2) @(posedge clk_i);
      #1 chk("smi_n clear", smi_n, 32'h1);
      wr(4'h2, 32'h0);
      // Each timer enable on its own, monitor enable left clear.
      for (i = 0; i < 3; i++) begin
         wr(4'h4, 32'h1 << i);
         io((i == 1) ? 16'h0062 : 16'h0066, f, r);
         chk("reload", r, 32'h1 << i);
      end
      rd(4'hF, d);
      chk("unmapped", d, 32'h0);
   endtask
   task automatic scn_power;
      logic f;
      logic [2:0] r;
      logic [31:0] d;
      // Device 10 powered down: decode off, trap on; the cycle still goes out.
      wr(4'h3, 32'h0);
      wr(4'h2, 32'h400);
      io(16'h0300, f, r);
      chk("down fwd", f, 32'h1);
      rd(4'h7, d);
      chk("down trap", d, 32'h400);
      wr(4'h7, 32'h400);
      // Device 10 back up, IDE device 2 powered down and trapped.
      wr(4'h3, 32'h400);
      wr(4'h2, 32'h4);
      io(16'h0300, f, r);
      chk("up fwd", f, 32'h1);
      rd(4'h7, d);
      chk("ide trap", d, 32'h4);
      wr(4'h7, 32'h4);
      wr(4'h2, 32'h0);
      repeat (2) @(posedge clk_i);
      #1 chk("power smi_n", smi_n, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         complete_run;
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'h1;
      scn_thermal_smi;
      scn_thermal_sci;
      scn_dev9;
      scn_power;
      complete_run;
   end
endmodule
